// File: uwc_mask_reg.v
// base address register whose writable bits follow a mask
`timescale 1ns/100ps
module uwc_mask_reg (
  input wire hclk, // core clock
  input wire hresetn, // async reset, active low
  input wire clk_en, // freezes the register while low
  input wire we, // write strobe
  input wire [31:0] wdata, // write data
  input wire [31:0] wmask, // bits that may be written
  output wire [31:0] q // masked contents
);
  reg [31:0] q_r;
  wire [31:0] q_nxt;

  assign q_nxt = (q_r & ~wmask) | (wdata & wmask);
  // bits outside the mask read zero even if they were written while wider
  assign q = q_r & wmask;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_r <= 32'h00000000;
    end else if (clk_en && we) begin
      q_r <= q_nxt;
    end
  end
endmodule // uwc_mask_reg

// File: uwc_regs.vh
// register offsets, field positions and reset values of the upstream window config bank
`ifndef UWC_REGS_VH
`define UWC_REGS_VH

// byte offsets of the words in this bank
`define UWC_OFF_WIDE_SETUP_LO 8'h34
`define UWC_OFF_WIDE_SETUP_HI 8'h38
`define UWC_OFF_PAGED_BASE 8'h5C
`define UWC_OFF_WIDE_BASE_LO 8'h60
`define UWC_OFF_WIDE_BASE_HI 8'h64
`define UWC_OFF_FWD_CTRL 8'h68
`define UWC_OFF_BOARD_ID 8'h6C
`define UWC_ADDR_W 8

// shared base register low bits
`define UWC_SPACE_BIT 0
`define UWC_TYPE_HI 2
`define UWC_TYPE_LO 1
`define UWC_PREF_BIT 3
`define UWC_TYPE_32 2'h0
`define UWC_TYPE_64 2'h1
`define UWC_PAGED_BASE_LSB 14
`define UWC_WIDE_BASE_LSB 12
`define UWC_SETUP_EN_BIT 31

// forwarding control word fields
`define UWC_TUNE_HI 15
`define UWC_TUNE_LO 0
`define UWC_DRV_NOM_HI 1
`define UWC_DRV_NOM_LO 0
`define UWC_DRV_SCALE_HI 5
`define UWC_DRV_SCALE_LO 2
`define UWC_DEEMPH_HI 11
`define UWC_DEEMPH_LO 8
`define UWC_TX_TERM_HI 13
`define UWC_TX_TERM_LO 12
`define UWC_RX_TERM_HI 15
`define UWC_RX_TERM_LO 14
`define UWC_PSIZE_HI 19
`define UWC_PSIZE_LO 16
`define UWC_PSIZE_EXT_BIT 20
`define UWC_FWD64_BIT 21
`define UWC_FRAG_HI 31
`define UWC_FRAG_LO 30

// reset values
`define UWC_TUNE_RST 16'h0800
`define UWC_PSIZE_RST 4'h0
`define UWC_FRAG_RST 2'h0
`define UWC_SETUP_RST 32'h00000000

// page size encoding: log2 of the page in bytes is code plus an offset
`define UWC_PSIZE_OFF_FINE 5'h07
`define UWC_PSIZE_OFF_COARSE 5'h16
`define UWC_PSIZE_COARSE_MAX 4'h3
`define UWC_PAGE_IDX_W 6
`define UWC_PAGE_CNT_LOG 5'h06

// write split boundaries in bytes
`define UWC_FRAG_32 8'h20
`define UWC_FRAG_64 8'h40
`define UWC_FRAG_128 8'h80

// ahb encodings
`define UWC_HTRANS_NONSEQ_BIT 1
`define UWC_HSIZE_WORD 3'h2

`endif

// File: uwc_window_cfg.v
// upstream window configuration registers with ahb-lite access and window decode
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "uwc_regs.vh"
module uwc_window_cfg #(
  parameter [15:0] BOARD_VENDOR_ID = 16'h5A5A, // arbitrary value
  parameter [15:0] BOARD_ID = 16'hA5C3 // arbitrary value
) (
  input wire hclk, // core clock
  input wire hresetn, // async reset, active low
  input wire clk_en, // freezes all state while low
  input wire hsel, // slave select
  input wire [31:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write when high
  input wire [2:0] hsize, // transfer size
  input wire hready, // bus ready in
  input wire [31:0] hwdata, // write data
  output wire hreadyout, // slave ready
  output wire hresp, // always okay
  output reg [31:0] hrdata, // read data
  input wire [63:0] up_addr, // upstream transaction address
  input wire up_is64, // transaction uses 64-bit address
  input wire down_wide_hit, // address falls in downstream wide window
  input wire [63:0] lut_page_valid, // bit 0 of each lookup entry
  output wire paged_claim, // paged window claims transaction
  output wire [5:0] paged_index, // lookup entry for the hit
  output wire [4:0] paged_shift, // log2 of page size
  output wire wide_claim, // wide window claims, untranslated
  output wire wide_fwd_up, // 64-bit transaction goes upstream
  output wire [1:0] drv_nominal, // tx nominal current select
  output wire [3:0] drv_scale, // tx current scale multiplier
  output wire [3:0] drv_deemph, // tx de-emphasis level
  output wire [1:0] tx_term, // tx termination select
  output wire [1:0] rx_term, // rx termination select
  output wire [7:0] write_split_bytes // upstream write split boundary
);
  // ahb data phase capture
  reg dp_wr_r;
  reg [`UWC_ADDR_W-1:0] dp_addr_r;
  wire ap_take;
  wire [`UWC_ADDR_W-1:0] ap_addr;
  reg [31:0] rd_nxt;

  // forwarding control word
  reg [15:0] tune_r;
  reg [3:0] psize_r;
  reg psize_ext_r;
  reg fwd64_r;
  reg [1:0] frag_r;

  // wide window setup words
  reg [31:0] setup_lo_r;
  reg [31:0] setup_hi_r;

  wire wr_paged;
  wire wr_wide_lo;
  wire wr_wide_hi;
  wire wr_ctrl;
  wire wr_setup_lo;
  wire wr_setup_hi;

  wire [31:0] paged_base_q;
  wire [31:0] wide_lo_q;
  wire [31:0] wide_hi_q;
  wire [31:0] paged_mask;
  wire [31:0] wide_lo_mask;
  wire [31:0] wide_hi_mask;

  wire paged_en;
  wire [4:0] pg_log;
  wire [4:0] win_log;
  wire [31:0] paged_win_mask;
  wire [31:0] page_shifted;
  wire paged_hit;
  wire wide_en_lo;
  wire wide_en_hi;
  wire wide_hit;
  wire [1:0] wide_type;
  wire [31:0] paged_word;
  wire [31:0] wide_lo_word;
  wire [31:0] wide_hi_word;
  wire [31:0] ctrl_word;
  wire [31:0] id_word;

  // ahb-lite slave: zero wait states while clk_en is high, read data registered at the
  // address phase so it stands in the data phase.  a master that
  // follows a write with idle in its data phase never reads a word
  // in the same cycle that word is written.
  assign hreadyout = clk_en;
  assign hresp = 1'b0;
  assign ap_take = hsel && hready && htrans[`UWC_HTRANS_NONSEQ_BIT] && clk_en;
  assign ap_addr = haddr[`UWC_ADDR_W-1:0];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= {`UWC_ADDR_W{1'b0}};
      hrdata <= 32'h00000000;
    end else if (clk_en) begin
      // sub-word writes are dropped: only whole words are supported
      dp_wr_r <= ap_take && hwrite && (hsize == `UWC_HSIZE_WORD);
      if (ap_take) begin
        dp_addr_r <= ap_addr;
      end
      if (ap_take && !hwrite) begin
        hrdata <= rd_nxt;
      end
    end
  end

  assign wr_paged = dp_wr_r && (dp_addr_r == `UWC_OFF_PAGED_BASE);
  assign wr_wide_lo = dp_wr_r && (dp_addr_r == `UWC_OFF_WIDE_BASE_LO);
  assign wr_wide_hi = dp_wr_r && (dp_addr_r == `UWC_OFF_WIDE_BASE_HI);
  assign wr_ctrl = dp_wr_r && (dp_addr_r == `UWC_OFF_FWD_CTRL);
  assign wr_setup_lo = dp_wr_r && (dp_addr_r == `UWC_OFF_WIDE_SETUP_LO);
  assign wr_setup_hi = dp_wr_r && (dp_addr_r == `UWC_OFF_WIDE_SETUP_HI);

  // forwarding control, tuning and write split word
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tune_r <= `UWC_TUNE_RST;
      psize_r <= `UWC_PSIZE_RST;
      psize_ext_r <= 1'b0;
      fwd64_r <= 1'b0;
      frag_r <= `UWC_FRAG_RST;
    end else if (clk_en && wr_ctrl) begin
      tune_r <= hwdata[`UWC_TUNE_HI:`UWC_TUNE_LO];
      psize_r <= hwdata[`UWC_PSIZE_HI:`UWC_PSIZE_LO];
      psize_ext_r <= hwdata[`UWC_PSIZE_EXT_BIT];
      fwd64_r <= hwdata[`UWC_FWD64_BIT];
      frag_r <= hwdata[`UWC_FRAG_HI:`UWC_FRAG_LO];
    end
  end

  // the tuning fields only steer the analogue front end
  assign drv_nominal = tune_r[`UWC_DRV_NOM_HI:`UWC_DRV_NOM_LO];
  assign drv_scale = tune_r[`UWC_DRV_SCALE_HI:`UWC_DRV_SCALE_LO];
  assign drv_deemph = tune_r[`UWC_DEEMPH_HI:`UWC_DEEMPH_LO];
  assign tx_term = tune_r[`UWC_TX_TERM_HI:`UWC_TX_TERM_LO];
  assign rx_term = tune_r[`UWC_RX_TERM_HI:`UWC_RX_TERM_LO];

  // upper bit set means 128 bytes whatever the low bit holds
  assign write_split_bytes = frag_r[1] ? `UWC_FRAG_128 :
                             (frag_r[0] ? `UWC_FRAG_64 : `UWC_FRAG_32);

  // wide window setup words, loaded before the window is used
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setup_lo_r <= `UWC_SETUP_RST;
      setup_hi_r <= `UWC_SETUP_RST;
    end else if (clk_en) begin
      if (wr_setup_lo) begin
        setup_lo_r <= hwdata;
      end
      if (wr_setup_hi) begin
        setup_hi_r <= hwdata;
      end
    end
  end

  // paged window size: code 0, and coarse codes above 3, disable it
  assign paged_en = (psize_r != 4'h0) &&
                    (!psize_ext_r || (psize_r <= `UWC_PSIZE_COARSE_MAX));
  assign pg_log = psize_ext_r ? ({1'b0, psize_r} + `UWC_PSIZE_OFF_COARSE) :
                                ({1'b0, psize_r} + `UWC_PSIZE_OFF_FINE);
  // window is 64 pages: log2 runs from 14 (16KB) to 31 (2GB)
  assign win_log = pg_log + `UWC_PAGE_CNT_LOG;
  assign paged_win_mask = 32'hFFFFFFFF << win_log;
  assign paged_mask = paged_en ? paged_win_mask : 32'h00000000;

  uwc_mask_reg u_paged_base (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .we(wr_paged),
    .wdata(hwdata),
    .wmask(paged_mask),
    .q(paged_base_q)
  );

  // wide window base words: with setup bit 31 set, setup bits one make base bits writable (low word from bit 12)
  assign wide_en_lo = setup_lo_r[`UWC_SETUP_EN_BIT];
  assign wide_en_hi = setup_hi_r[`UWC_SETUP_EN_BIT];
  assign wide_lo_mask = wide_en_lo ?
                        {setup_lo_r[31:`UWC_WIDE_BASE_LSB], {`UWC_WIDE_BASE_LSB{1'b0}}} :
                        32'h00000000;
  assign wide_hi_mask = wide_en_hi ? setup_hi_r : 32'h00000000;

  uwc_mask_reg u_wide_lo (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .we(wr_wide_lo),
    .wdata(hwdata),
    .wmask(wide_lo_mask),
    .q(wide_lo_q)
  );

  uwc_mask_reg u_wide_hi (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .we(wr_wide_hi),
    .wdata(hwdata),
    .wmask(wide_hi_mask),
    .q(wide_hi_q)
  );

  // reserved type codes from setup read back as the 32-bit type
  assign wide_type = (setup_lo_r[`UWC_TYPE_HI:`UWC_TYPE_LO] == `UWC_TYPE_64) ?
                     `UWC_TYPE_64 : `UWC_TYPE_32;

  // paged window decode and page selection
  assign paged_hit = paged_en && (up_addr[63:32] == 32'h00000000) &&
                     ((up_addr[31:0] & paged_win_mask) ==
                      (paged_base_q & paged_win_mask));
  assign page_shifted = up_addr[31:0] >> pg_log;
  assign paged_index = page_shifted[`UWC_PAGE_IDX_W-1:0];
  assign paged_shift = pg_log;
  // a cleared valid bit makes the page transparent to the decoder
  assign paged_claim = paged_hit && lut_page_valid[paged_index];

  // wide window decode: full 64-bit compare under the setup masks
  assign wide_hit = wide_en_lo && wide_en_hi && up_is64 &&
                    ((up_addr[31:0] & wide_lo_mask) == wide_lo_q) &&
                    ((up_addr[63:32] & wide_hi_mask) == wide_hi_q);
  assign wide_claim = fwd64_r && wide_hit;
  // with the enable clear every 64-bit access outside the downstream
  // window goes up; with it set only hits in the wide window do
  assign wide_fwd_up = up_is64 && (fwd64_r ? wide_hit : !down_wide_hit);

  // read words
  assign paged_word = {paged_base_q[31:`UWC_PAGED_BASE_LSB],
                       {(`UWC_PAGED_BASE_LSB - 4){1'b0}},
                       1'b0, `UWC_TYPE_32, 1'b0};
  assign wide_lo_word = {wide_lo_q[31:`UWC_WIDE_BASE_LSB],
                         {(`UWC_WIDE_BASE_LSB - 4){1'b0}},
                         setup_lo_r[`UWC_PREF_BIT] & wide_en_lo,
                         wide_type & {2{wide_en_lo}}, 1'b0};
  assign wide_hi_word = wide_hi_q;
  assign ctrl_word = {frag_r, 8'h00, fwd64_r, psize_ext_r, psize_r, tune_r};
  assign id_word = {BOARD_ID, BOARD_VENDOR_ID};

  always @* begin
    case (ap_addr)
      `UWC_OFF_WIDE_SETUP_LO: rd_nxt = setup_lo_r;
      `UWC_OFF_WIDE_SETUP_HI: rd_nxt = setup_hi_r;
      `UWC_OFF_PAGED_BASE: rd_nxt = paged_word;
      `UWC_OFF_WIDE_BASE_LO: rd_nxt = wide_lo_word;
      `UWC_OFF_WIDE_BASE_HI: rd_nxt = wide_hi_word;
      `UWC_OFF_FWD_CTRL: rd_nxt = ctrl_word;
      `UWC_OFF_BOARD_ID: rd_nxt = id_word;
      default: rd_nxt = 32'h00000000;
    endcase
  end
endmodule // uwc_window_cfg

// File: uwc_window_cfg_sva.sv
// assertion checker of the upstream window config bank
`timescale 1ns/100ps
module uwc_window_cfg_chk #(
  parameter [15:0] BOARD_VENDOR_ID = 16'hC35A, // arbitrary value
  parameter [15:0] BOARD_ID = 16'h3CA5 // arbitrary value
) (
  input wire hclk, // core clock
  input wire hresetn, // async reset, active low
  input wire clk_en, // clock enable
  input wire hsel, // slave select
  input wire [31:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write when high
  input wire hready, // bus ready
  input wire [31:0] hrdata, // read data
  input wire [63:0] up_addr, // upstream address
  input wire up_is64, // 64-bit transaction
  input wire [63:0] lut_page_valid, // lookup entry valid bits
  input wire paged_claim, // paged window claim
  input wire [5:0] paged_index, // lookup entry index
  input wire [4:0] paged_shift, // log2 page size
  input wire wide_claim, // wide window claim
  input wire wide_fwd_up, // forwarded upstream
  input wire [3:0] drv_scale, // tx current scale
  input wire [7:0] write_split_bytes // write split boundary
);
  logic rd_r;
  logic [7:0] ra_r;
  // marks the data phase of a taken read, when hrdata holds its answer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_r <= 1'b0;
      ra_r <= 8'h00;
    end else if (clk_en) begin
      rd_r <= hsel & hready & htrans[1] & ~hwrite;
      ra_r <= haddr[7:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  page_valid_a: assert property (paged_claim |-> lut_page_valid[paged_index])
    else $error("paged claim on an invalid page");
  page_index_a: assert property (
    paged_claim |-> paged_index == 6'(up_addr[31:0] >> paged_shift))
    else $error("paged index not taken above page size");
  page_size_a: assert property (paged_claim |-> paged_shift inside {[8:25]})
    else $error("paged claim with illegal page size");
  low_window_a: assert property (paged_claim |-> up_addr[63:32] == 32'h0)
    else $error("paged claim above four gigabytes");
  wide_fwd_a: assert property (wide_claim |-> wide_fwd_up)
    else $error("wide claim not forwarded upstream");
  wide_only64_a: assert property (!up_is64 |-> !wide_fwd_up && !wide_claim)
    else $error("wide window acts on a 32-bit address");
  split_enc_a: assert property (write_split_bytes inside {8'h20, 8'h40, 8'h80})
    else $error("write split boundary out of range");
  reset_tune_a: assert property (
    $rose(hresetn) |-> drv_scale == 4'h0 && write_split_bytes == 8'h20)
    else $error("tuning fields wrong after reset");
  type_paged_a: assert property (rd_r && ra_r == 8'h5C |-> hrdata[3:0] == 4'h0)
    else $error("paged base low bits not fixed");
  type_wide_a: assert property (
    rd_r && ra_r == 8'h60 |-> hrdata[2] == 1'b0 && hrdata[11:4] == 8'h00)
    else $error("wide base reports reserved type");
  board_ids_a: assert property (
    rd_r && ra_r == 8'h6C |-> hrdata == {BOARD_ID, BOARD_VENDOR_ID})
    else $error("board identifiers wrong");
endmodule // uwc_window_cfg_chk

bind uwc_window_cfg uwc_window_cfg_chk #(.BOARD_VENDOR_ID(BOARD_VENDOR_ID), .BOARD_ID(BOARD_ID))
  chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .up_addr(up_addr),
  .up_is64(up_is64), .lut_page_valid(lut_page_valid), .paged_claim(paged_claim),
  .paged_index(paged_index), .paged_shift(paged_shift), .wide_claim(wide_claim),
  .wide_fwd_up(wide_fwd_up), .drv_scale(drv_scale), .write_split_bytes(write_split_bytes));

// File: uwc_window_cfg_tb_top.sv
// self-checking testbench of the upstream window config bank
`timescale 1ns/100ps
`include "uwc_regs.vh"
module uwc_window_cfg_tb_top;
  localparam [15:0] VID = 16'h3C5A; // arbitrary value
  localparam [15:0] BID = 16'h69C1; // arbitrary value
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [63:0] up_addr = 64'h0;
  logic up_is64 = 1'b0;
  logic down_wide_hit = 1'b0;
  logic [63:0] lut_page_valid = 64'h0;
  wire hready, hresp, paged_claim, wide_claim, wide_fwd_up;
  wire [1:0] drv_nominal, tx_term, rx_term;
  wire [31:0] hrdata;
  wire [5:0] paged_index;
  wire [4:0] paged_shift;
  wire [3:0] drv_scale, drv_deemph;
  wire [7:0] write_split_bytes;
  int fails = 0;
  int checked = 0;
  always #4 hclk = ~hclk;
  uwc_window_cfg #(.BOARD_VENDOR_ID(VID), .BOARD_ID(BID)) uut (.hclk(hclk),
    .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .up_addr(up_addr), .up_is64(up_is64),
    .down_wide_hit(down_wide_hit), .lut_page_valid(lut_page_valid),
    .paged_claim(paged_claim), .paged_index(paged_index), .paged_shift(paged_shift),
    .wide_claim(wide_claim), .wide_fwd_up(wide_fwd_up), .drv_nominal(drv_nominal),
    .drv_scale(drv_scale), .drv_deemph(drv_deemph), .tx_term(tx_term), .rx_term(rx_term),
    .write_split_bytes(write_split_bytes));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single word transfer; no wait count assumed, the watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic probe(input logic [63:0] a, input logic [63:0] v, input logic w, input logic d);
    @(posedge hclk);
    up_addr <= a;
    lut_page_valid <= v;
    up_is64 <= w;
    down_wide_hit <= d;
    @(negedge hclk);
  endtask
  task automatic t_reset;
    rd(8'h5C, 32'h0);
    rd(8'h60, 32'h0);
    rd(8'h64, 32'h0);
    rd(8'h68, {16'h0, `UWC_TUNE_RST});
    rd(8'h6C, {BID, VID});
    wr(8'h6C, 32'hFFFFFFFF);
    rd(8'h6C, {BID, VID});
    rd(8'h40, 32'h0);
    chk(drv_scale, 4'h0);
    chk(write_split_bytes, 8'h20);
    chk({hresp, drv_nominal, drv_deemph, tx_term, rx_term}, {1'b0, 2'h0, 4'h8, 2'h0, 2'h0});
  endtask
  task automatic t_pages;
    int sh;
    logic en;
    for (int e = 0; e < 2; e++) begin
      for (int c = 0; c < 16; c++) begin
        sh = e ? c + 22 : c + 7;
        en = (c != 0) && (e == 0 || c < 4);
        wr(8'h68, {11'h0, e[0], c[3:0], 16'h0});
        wr(8'h5C, 32'hFFFFFFFF);
        rd(8'h5C, en ? 32'hFFFFFFFF << (sh + 6) : 32'h0);
        if (en) chk(paged_shift, sh);
      end
    end
  endtask
  task automatic t_paged;
    wr(8'h68, 32'h00010000);
    wr(8'h5C, 32'h00004000);
    probe(64'h4503, ~(64'h1 << 5), 1'b0, 1'b0);
    chk(paged_claim, 1'b0);
    probe(64'h4503, ~64'h0, 1'b0, 1'b0);
    chk({paged_claim, paged_index}, 7'h45);
    probe(64'h1_0000_4503, ~64'h0, 1'b0, 1'b0);
    chk(paged_claim, 1'b0);
  endtask
  task automatic t_wide;
    wr(8'h34, 32'hFFFF0002);
    wr(8'h38, 32'h800000FF);
    wr(8'h60, 32'hFFFFFFFF);
    rd(8'h60, 32'hFFFF0002);
    wr(8'h64, 32'hFFFFFFFF);
    rd(8'h64, 32'h800000FF);
    wr(8'h60, 32'h12340000);
    wr(8'h64, 32'h00000005);
    wr(8'h68, 32'h0);
    probe(64'h5_1234ABCD, 64'h0, 1'b1, 1'b0);
    chk({wide_claim, wide_fwd_up}, 2'h1);
    probe(64'h5_1234ABCD, 64'h0, 1'b1, 1'b1);
    chk(wide_fwd_up, 1'b0);
    wr(8'h68, 32'h00200000);
    probe(64'h5_1234ABCD, 64'h0, 1'b1, 1'b1);
    chk({wide_claim, wide_fwd_up}, 2'h3);
    probe(64'h6_1234ABCD, 64'h0, 1'b1, 1'b0);
    chk({wide_claim, wide_fwd_up}, 2'h0);
    wr(8'h34, 32'h7FFF0002);
    rd(8'h60, 32'h0);
    probe(64'h5_1234ABCD, 64'h0, 1'b1, 1'b0);
    chk(wide_claim, 1'b0);
    wr(8'h34, 32'hFFFF0006);
    rd(8'h60, 32'h12340000);
  endtask
  task automatic t_split;
    for (int c = 0; c < 4; c++) begin
      wr(8'h68, {c[1:0], 30'h3FC0A53C});
      rd(8'h68, {c[1:0], 30'h0000A53C});
      chk(write_split_bytes, c == 0 ? 8'h20 : (c == 1 ? 8'h40 : 8'h80));
    end
    chk(drv_scale, 4'hF);
    chk({drv_nominal, drv_deemph, tx_term, rx_term}, {2'h0, 4'h5, 2'h2, 2'h2});
  endtask
  // a write launched while the bank is frozen must wait for the enable
  task automatic t_freeze;
    @(posedge hclk);
    clk_en <= 1'b0;
    @(negedge hclk);
    chk(hready, 1'b0);
    fork
      wr(8'h68, 32'h40000000);
      begin
        repeat (3) @(posedge hclk);
        chk(write_split_bytes, 8'h80);
        clk_en <= 1'b1;
      end
    join
    rd(8'h68, 32'h40000000);
    chk(write_split_bytes, 8'h40);
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_pages;
    t_paged;
    t_wide;
    t_split;
    t_freeze;
    end_of_test;
  end
  // the whole run takes about four hundred cycles
  initial begin
    #100000;
    fails++;
    end_of_test;
  end
endmodule // uwc_window_cfg_tb_top
